// >>> shared/lmc_pkg.sv
package lmc_pkg;
   // status longword field positions
   localparam int PSL_C = 0;
   localparam int PSL_V = 1;
   localparam int PSL_Z = 2;
   localparam int PSL_N = 3;
   localparam int PSL_T = 4;
   localparam int PSL_IV = 5;
   localparam int PSL_FU = 6;
   localparam int PSL_DV = 7;
   localparam int PSL_IPL_LO = 16;
   localparam int PSL_IPL_HI = 20;
   localparam int PSL_PRV_LO = 22;
   localparam int PSL_PRV_HI = 23;
   localparam int PSL_CUR_LO = 24;
   localparam int PSL_CUR_HI = 25;
   localparam int PSL_IS = 26;
   localparam int PSL_FPD = 27;
   localparam int PSL_TP = 30;
   localparam int PSL_CM = 31;
   // legacy status word: low bits kept, upper bits ignored or checked
   localparam int PSW_KEEP_HI = 4;
   localparam int PSW_UPPER_LO = 5;
   localparam int PSW_UPPER_HI = 15;
   localparam logic [1:0] LEVEL_USER = 2'h3;
   // compat address space
   localparam int CADDR_W = 16;
   localparam int VADDR_W = 32;
   localparam int PAGE_LO = 9;
   localparam int PAGE_W = 7;
   // exception frame
   localparam logic [1:0] FRAME_LW_COMPAT = 2'h3;
   localparam logic [1:0] FRAME_LW_TRACE = 2'h2;
   localparam int CODE_W = 16;
   // register map, byte addresses
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_LAST_CODE = 8'h0C;
   localparam logic [7:0] REG_FAULT_CAUSE = 8'h10;
   localparam int IRQ_W = 4;
   localparam int IRQ_ENTER = 0;
   localparam int IRQ_EXIT = 1;
   localparam int IRQ_RSVD = 2;
   localparam int IRQ_FRAME = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   typedef enum logic [1:0] {
      LMC_EXC_NATIVE,
      LMC_EXC_COMPAT,
      LMC_EXC_TRACE
   } lmc_exc_kind_t;

   typedef struct packed {
      logic valid;
      logic [31:0] psl;
   } lmc_rei_req_t;

   typedef struct packed {
      logic valid;
      logic fault;
      logic entered;
   } lmc_rei_rsp_t;

   typedef struct packed {
      logic valid;
      lmc_exc_kind_t kind;
      logic needs_backup;
      logic [CODE_W-1:0] code;
      logic [31:0] pc;
   } lmc_exc_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } lmc_push_t;
endpackage : lmc_pkg

// >>> design/lmc_psl_check.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_psl_check (
   input wire logic [31:0] psl_i, // status longword image being restored
   output logic fault_o, // reserved operand fault
   output logic [3:0] cause_o // [0] cur [1] prv [2] upper status word [3] fpd/ipl/is
);
   always_comb begin
      cause_o[0] = psl_i[lmc_pkg::PSL_CUR_HI:lmc_pkg::PSL_CUR_LO] != lmc_pkg::LEVEL_USER;
      cause_o[1] = psl_i[lmc_pkg::PSL_PRV_HI:lmc_pkg::PSL_PRV_LO] != lmc_pkg::LEVEL_USER;
      // covers decimal, float-underflow and integer-overflow enables too
      cause_o[2] = |psl_i[lmc_pkg::PSW_UPPER_HI:lmc_pkg::PSW_UPPER_LO];
      cause_o[3] = psl_i[lmc_pkg::PSL_FPD] | psl_i[lmc_pkg::PSL_IS]
         | (|psl_i[lmc_pkg::PSL_IPL_HI:lmc_pkg::PSL_IPL_LO]);
      fault_o = |cause_o;
   end
endmodule : lmc_psl_check
`default_nettype wire

// >>> design/lmc_frame_push.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_frame_push (
   input wire logic sys_clk_i, // core clock
   input wire logic rstn_i, // sync reset, active low
   input wire logic start_i, // begin a frame
   input wire logic [1:0] count_i, // longwords in frame
   input wire logic [31:0] psl_i, // stacked status longword
   input wire logic [31:0] pc_i, // stacked program counter
   input wire logic [31:0] info_i, // exception-specific longword
   input wire logic push_ready_i, // stack writer takes a word
   output lmc_pkg::lmc_push_t push_o, // word to push
   output logic busy_o // frame in progress
);
   typedef enum logic {FP_IDLE, FP_PUSH} lmc_fp_state_t;
   lmc_fp_state_t state, next_state;
   logic [1:0] idx, next_idx;
   logic [1:0] cnt, next_cnt;
   logic [31:0] words [3];
   logic [31:0] next_words [3];

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_cnt = cnt;
      next_words = words;
      case (state)
         FP_IDLE: begin
            if (start_i) begin
               next_state = FP_PUSH;
               next_idx = 2'h0;
               next_cnt = count_i;
               next_words[0] = psl_i;
               next_words[1] = pc_i;
               next_words[2] = info_i;
            end
         end
         FP_PUSH: begin
            if (push_ready_i) begin
               next_idx = idx + 2'h1;
               if (idx + 2'h1 == cnt) begin
                  // park the index on a real entry so idle data never reads past the store
                  next_state = FP_IDLE;
                  next_idx = 2'h0;
               end
            end
         end
         default: next_state = FP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state <= FP_IDLE;
         idx <= 2'h0;
         cnt <= 2'h0;
         words <= '{32'h0, 32'h0, 32'h0};
      end else begin
         state <= next_state;
         idx <= next_idx;
         cnt <= next_cnt;
         words <= next_words;
      end
   end

   always_comb begin
      push_o.valid = state == FP_PUSH;
      push_o.data = words[idx];
      busy_o = state == FP_PUSH;
   end
endmodule : lmc_frame_push
`default_nettype wire

// >>> design/lmc_mode_ctrl.sv
// What this block does
// - Return-from-exception with the popped mode flag set enters compatibility mode.
// - Entry needs current and previous access levels both equal to 3, else fault.
// - Entry faults if overflow, underflow, part-done, priority or stack-flag fields nonzero.
// - Condition codes, trace and trace-pending keep native meaning in compat mode.
// - Any exception or interrupt taken leaves compatibility mode for native mode.
// - Saved status longword on exit holds the values the entry check demands.
// - Legacy return-from-interrupt or trap ignores upper 11 bits of popped status word.
// - Restoring status word into the longword on entry needs upper bits zero.
// - Compat addresses are 16-bit, confined to lowest 64 Kbytes of process space.
// - A compat address maps to the identical native virtual address.
// - Compat addresses use the normal translation and protection path.
// - Protection granularity is the 512-byte page, 128 pages in compat space.
// - Partial side effects of the interrupted instruction are undone before exit.
// - Compat-specific exceptions push status longword, program counter, info longword.
// - Info longword carries exception code in bits 15..0, zeros in 31..16.
// - Compat-specific exceptions are faults or aborts, never traps.
// - Compat trace fault pushes two longwords, priority and stack flag zero, mode one.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module lmc_mode_ctrl (
   input wire logic sys_clk_i, // core clock, 200 MHz
   input wire logic rstn_i, // sync reset, active low
   // wishbone classic slave
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic irq_o, // level interrupt
   // core side
   input wire lmc_pkg::lmc_rei_req_t rei_i, // return-from-exception executing
   output lmc_pkg::lmc_rei_rsp_t rei_o, // outcome, one cycle later
   input wire logic lret_valid_i, // legacy return from interrupt/trap
   input wire logic [15:0] lret_psw_i, // popped legacy status word
   input wire logic cc_valid_i, // condition code update from execution
   input wire logic [3:0] cc_i, // new N Z V C
   input wire lmc_pkg::lmc_exc_req_t exc_i, // exception or interrupt taken
   output logic exc_ready_o, // exception accepted
   input wire logic [31:0] inst_pc_i, // pc of current instruction start
   output logic backup_o, // undo partial side effects, pulse
   output lmc_pkg::lmc_push_t push_o, // kernel stack push
   input wire logic push_ready_i, // push accepted
   output logic legacy_mode_flag_o, // in compatibility mode
   output logic [31:0] status_longword_o, // current status longword image
   input wire logic caddr_valid_i, // compat address valid
   input wire logic [15:0] caddr_i, // compat byte address
   output logic vaddr_valid_o, // translated request valid
   output logic [31:0] vaddr_o, // native virtual address
   output logic [6:0] vpage_o // page index inside compat space
);
   logic mode, next_mode;
   logic [3:0] cc, next_cc;
   logic trace, next_trace;
   logic tp, next_tp;
   logic [15:0] last_code, next_last_code;
   logic [3:0] fault_cause, next_fault_cause;
   lmc_pkg::lmc_rei_rsp_t rei_rsp, next_rei_rsp;
   logic backup, next_backup;
   logic [lmc_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [lmc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic va_valid, next_va_valid;
   logic [31:0] va, next_va;
   logic [6:0] vpage, next_vpage;
   logic chk_fault;
   logic [3:0] chk_cause;
   logic fp_busy;
   logic fp_start;
   logic [1:0] fp_count;
   logic [31:0] saved_psl;
   logic [31:0] info;
   logic [31:0] cur_psl;
   logic exc_take;
   logic rei_enter;
   logic rei_fault;
   logic wb_req;
   logic [lmc_pkg::IRQ_W-1:0] ev;

   lmc_psl_check u_check (
      .psl_i(rei_i.psl),
      .fault_o(chk_fault),
      .cause_o(chk_cause)
   );

   // status longword while in compat mode: checked fields at their entry values
   always_comb begin
      cur_psl = 32'h0;
      cur_psl[lmc_pkg::PSL_CM] = mode;
      cur_psl[lmc_pkg::PSL_TP] = tp;
      cur_psl[lmc_pkg::PSL_CUR_HI:lmc_pkg::PSL_CUR_LO] = lmc_pkg::LEVEL_USER;
      cur_psl[lmc_pkg::PSL_PRV_HI:lmc_pkg::PSL_PRV_LO] = lmc_pkg::LEVEL_USER;
      cur_psl[lmc_pkg::PSL_T] = trace;
      cur_psl[lmc_pkg::PSL_N:lmc_pkg::PSL_C] = cc;
      // priority, stack flag, part-done and enables stay zero
      saved_psl = cur_psl;
      saved_psl[lmc_pkg::PSL_CM] = 1'b1;
      info = {16'h0000, exc_i.code};
   end

   // a native-mode exception is the native sequencer's business, but exc_ready_o stalls every exception while a frame is pushing
   assign exc_take = exc_i.valid && mode && !fp_busy;
   assign exc_ready_o = !fp_busy;
   assign rei_enter = rei_i.valid && !exc_take && rei_i.psl[lmc_pkg::PSL_CM] && !chk_fault;
   assign rei_fault = rei_i.valid && !exc_take && rei_i.psl[lmc_pkg::PSL_CM] && chk_fault;

   always_comb begin
      next_mode = mode;
      next_cc = cc;
      next_trace = trace;
      next_tp = tp;
      next_last_code = last_code;
      next_fault_cause = fault_cause;
      next_backup = 1'b0;
      fp_start = 1'b0;
      fp_count = lmc_pkg::FRAME_LW_COMPAT;
      next_rei_rsp = '0;
      ev = '0;
      if (exc_take) begin
         next_mode = 1'b0;
         next_backup = exc_i.needs_backup;
         ev[lmc_pkg::IRQ_EXIT] = 1'b1;
         case (exc_i.kind)
            lmc_pkg::LMC_EXC_COMPAT: begin
               fp_start = 1'b1;
               fp_count = lmc_pkg::FRAME_LW_COMPAT;
               next_last_code = exc_i.code;
               ev[lmc_pkg::IRQ_FRAME] = 1'b1;
            end
            lmc_pkg::LMC_EXC_TRACE: begin
               fp_start = 1'b1;
               fp_count = lmc_pkg::FRAME_LW_TRACE;
               ev[lmc_pkg::IRQ_FRAME] = 1'b1;
            end
            default: fp_start = 1'b0;
         endcase
      end else if (rei_i.valid) begin
         next_rei_rsp.valid = 1'b1;
         if (rei_enter) begin
            next_mode = 1'b1;
            next_cc = rei_i.psl[lmc_pkg::PSL_N:lmc_pkg::PSL_C];
            next_trace = rei_i.psl[lmc_pkg::PSL_T];
            next_tp = rei_i.psl[lmc_pkg::PSL_TP];
            next_rei_rsp.entered = 1'b1;
            ev[lmc_pkg::IRQ_ENTER] = 1'b1;
         end else if (rei_fault) begin
            next_rei_rsp.fault = 1'b1;
            next_fault_cause = chk_cause;
            ev[lmc_pkg::IRQ_RSVD] = 1'b1;
         end
      end else if (mode && lret_valid_i) begin
         next_cc = lret_psw_i[lmc_pkg::PSL_N:lmc_pkg::PSL_C];
         next_trace = lret_psw_i[lmc_pkg::PSW_KEEP_HI];
      end else if (mode && cc_valid_i) begin
         next_cc = cc_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         mode <= 1'b0;
         cc <= 4'h0;
         trace <= 1'b0;
         tp <= 1'b0;
         last_code <= 16'h0000;
         fault_cause <= 4'h0;
         rei_rsp <= '0;
         backup <= 1'b0;
      end else begin
         mode <= next_mode;
         cc <= next_cc;
         trace <= next_trace;
         tp <= next_tp;
         last_code <= next_last_code;
         fault_cause <= next_fault_cause;
         rei_rsp <= next_rei_rsp;
         backup <= next_backup;
      end
   end

   // pc is the instruction start so the exception restarts it as a fault
   lmc_frame_push u_push (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .start_i(fp_start),
      .count_i(fp_count),
      .psl_i(saved_psl),
      .pc_i(inst_pc_i),
      .info_i(info),
      .push_ready_i(push_ready_i),
      .push_o(push_o),
      .busy_o(fp_busy)
   );

   // address path: zero-extend, identity map, page index for protection
   always_comb begin
      next_va_valid = caddr_valid_i && mode;
      next_va = {{(lmc_pkg::VADDR_W-lmc_pkg::CADDR_W){1'b0}}, caddr_i};
      next_vpage = caddr_i[lmc_pkg::CADDR_W-1:lmc_pkg::PAGE_LO];
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         va_valid <= 1'b0;
         va <= 32'h0;
         vpage <= 7'h00;
      end else begin
         va_valid <= next_va_valid;
         va <= next_va;
         vpage <= next_vpage;
      end
   end

   // register slave: one wait state, unmapped reads give zero
   assign wb_req = wb_cyc_i && wb_stb_i && !ack;

   always_comb begin
      next_ack = wb_req;
      next_rdata = 32'h0;
      next_irq_mask = irq_mask;
      // hardware set wins over a same-cycle write-one clear
      next_irq_stat = irq_stat | ev;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            lmc_pkg::REG_IRQ_STAT: next_irq_stat = (irq_stat & ~wb_dat_i[3:0]) | ev;
            lmc_pkg::REG_IRQ_MASK: next_irq_mask = wb_dat_i[3:0];
            default: next_irq_mask = irq_mask;
         endcase
      end
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            lmc_pkg::REG_STATUS: next_rdata = {24'h0, cc, trace, tp, fp_busy, mode};
            lmc_pkg::REG_IRQ_STAT: next_rdata = {28'h0, irq_stat};
            lmc_pkg::REG_IRQ_MASK: next_rdata = {28'h0, irq_mask};
            lmc_pkg::REG_LAST_CODE: next_rdata = {16'h0, last_code};
            lmc_pkg::REG_FAULT_CAUSE: next_rdata = {28'h0, fault_cause};
            default: next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ack <= 1'b0;
         rdata <= 32'h0;
         irq_stat <= '0;
         irq_mask <= lmc_pkg::IRQ_MASK_RST;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
   assign irq_o = |(irq_stat & irq_mask);
   assign rei_o = rei_rsp;
   assign backup_o = backup;
   assign legacy_mode_flag_o = mode;
   assign status_longword_o = cur_psl;
   assign vaddr_valid_o = va_valid;
   assign vaddr_o = va;
   assign vpage_o = vpage;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_good_rei;
      rei_i.valid && !exc_take && rei_i.psl[lmc_pkg::PSL_CM] && !chk_fault;
   endsequence
   sequence s_compat_exc;
      exc_take && exc_i.kind == lmc_pkg::LMC_EXC_COMPAT;
   endsequence

   property p_enter;
      s_good_rei |=> mode && rei_o.entered && rei_o.valid;
   endproperty
   a_enter: assert property (p_enter) else $error("good return did not enter mode");

   property p_bad_level;
      rei_i.valid && !exc_take && rei_i.psl[lmc_pkg::PSL_CM]
         && rei_i.psl[lmc_pkg::PSL_CUR_HI:lmc_pkg::PSL_CUR_LO] != lmc_pkg::LEVEL_USER
         |=> rei_o.fault && !rei_o.entered && $stable(mode);
   endproperty
   a_bad_level: assert property (p_bad_level) else $error("bad access level not faulted");

   property p_bad_field;
      rei_i.valid && !exc_take && rei_i.psl[lmc_pkg::PSL_CM]
         && (rei_i.psl[lmc_pkg::PSL_FPD] || rei_i.psl[lmc_pkg::PSL_IS]
         || rei_i.psl[lmc_pkg::PSL_DV]) |=> rei_o.fault && fault_cause != 4'h0;
   endproperty
   a_bad_field: assert property (p_bad_field) else $error("nonzero field not faulted");

   property p_exit;
      exc_take |=> !mode;
   endproperty
   a_exit: assert property (p_exit) else $error("exception did not leave mode");

   property p_lret;
      mode && lret_valid_i && !exc_take && !rei_i.valid
         |=> cc == $past(lret_psw_i[3:0]) && trace == $past(lret_psw_i[4]);
   endproperty
   a_lret: assert property (p_lret) else $error("legacy return low bits wrong");

   property p_addr;
      caddr_valid_i && mode |=> vaddr_valid_o && vaddr_o == {16'h0, $past(caddr_i)}
         && vpage_o == $past(caddr_i[15:9]);
   endproperty
   a_addr: assert property (p_addr) else $error("compat address mapping wrong");

   // with ready every cycle the third word is the info word and the frame ends after it
   property p_frame3;
      s_compat_exc ##1 push_ready_i [*3] |-> push_o.valid
         && push_o.data[31:16] == 16'h0000 ##1 !push_o.valid;
   endproperty
   a_frame3: assert property (p_frame3) else $error("compat frame not three words");

   property p_psl_saved;
      exc_take && exc_i.kind != lmc_pkg::LMC_EXC_NATIVE |=> push_o.valid
         && push_o.data[lmc_pkg::PSL_CM] && !push_o.data[lmc_pkg::PSL_IS]
         && push_o.data[lmc_pkg::PSL_IPL_HI:lmc_pkg::PSL_IPL_LO] == 5'h00;
   endproperty
   a_psl_saved: assert property (p_psl_saved) else $error("stacked longword wrong");

   property p_backup;
      exc_take && exc_i.needs_backup |=> backup_o ##1 !backup_o;
   endproperty
   a_backup: assert property (p_backup) else $error("backup pulse missing");

   property p_trace2;
      exc_take && exc_i.kind == lmc_pkg::LMC_EXC_TRACE ##1 push_ready_i [*2]
         |-> push_o.valid ##1 !push_o.valid;
   endproperty
   a_trace2: assert property (p_trace2) else $error("trace frame not two words");
endmodule : lmc_mode_ctrl
`default_nettype wire

// >>> test/lmc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_core_model (
   input wire logic sys_clk_i, // core clock
   input wire logic rstn_i, // sync reset, active low
   input wire logic slow_i, // ready only every other cycle, so each word is held
   input wire lmc_pkg::lmc_push_t push_i, // word offered for the kernel stack
   output logic push_ready_o // word taken at this edge
);
   logic [31:0] words [0:15];
   int n = 0;
   // a slow stack writer gaps its ready so the frame pusher must hold each word
   always_ff @(posedge sys_clk_i) begin
      push_ready_o <= rstn_i & (~slow_i | ~push_ready_o);
      if (push_i.valid && push_ready_o && n < 16) begin
         words[n] <= push_i.data;
         n <= n + 1;
      end
   end
endmodule : lmc_core_model
`default_nettype wire

// >>> test/lmc_mode_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module lmc_mode_ctrl_tb_top;
   localparam logic [31:0] PC = 32'h0000_2468;
   logic sys_clk_i = 1'b0, rstn_i = 1'b0, slow_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF, cc_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, inst_pc_i = PC, wb_dat_o, status_longword_o, vaddr_o;
   logic lret_valid_i = 1'b0, cc_valid_i = 1'b0, caddr_valid_i = 1'b0, push_ready_i;
   logic exc_ready_o, backup_o, legacy_mode_flag_o, vaddr_valid_o;
   logic [15:0] lret_psw_i = 16'h0, caddr_i = 16'h0;
   logic [6:0] vpage_o;
   lmc_pkg::lmc_rei_req_t rei_i = '0;
   lmc_pkg::lmc_rei_rsp_t rei_o;
   lmc_pkg::lmc_exc_req_t exc_i = '0;
   lmc_pkg::lmc_push_t push_o;
   int bad_count = 0, checks = 0;
   // reserved operand cases: cur, prv, dv, fpd, fu, ipl, is, iv, status word bits 15 and 8
   logic [31:0] bad [11] = '{32'h82C00000, 32'h83800000, 32'h83C00080, 32'h8BC00000,
      32'h83C00040, 32'h83C10000, 32'h87C00000, 32'h83C00020, 32'h83C08000, 32'h83C00100,
      32'h81C00000};
   logic [15:0] adrs [3] = '{16'h0000, 16'hFFFF, 16'h0200};

   lmc_mode_ctrl i_lmc_mode_ctrl (.sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .rei_i, .rei_o,
      .lret_valid_i, .lret_psw_i, .cc_valid_i, .cc_i, .exc_i, .exc_ready_o, .inst_pc_i,
      .backup_o, .push_o, .push_ready_i, .legacy_mode_flag_o, .status_longword_o,
      .caddr_valid_i, .caddr_i, .vaddr_valid_o, .vaddr_o, .vpage_o);
   lmc_core_model i_lmc_core_model (.sys_clk_i, .rstn_i, .slow_i, .push_i(push_o),
      .push_ready_o(push_ready_i));

   always #2.5 sys_clk_i = ~sys_clk_i;

   task automatic finish_test();
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        input logic [3:0] sel, output logic [31:0] rd);
      int k;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      k = 0;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50)
         bad_count++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      #1;
   endtask : wb_io

   task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_io(1'b0, adr, 32'h0, 4'hF, rd);
      `CHK(rd, exp)
   endtask : wb_rd

   task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] rd;
      wb_io(1'b1, adr, dat, sel, rd);
   endtask : wb_wr

   task automatic rei_go(input logic [31:0] p, input logic [2:0] exp);
      @(posedge sys_clk_i);
      rei_i <= '{1'b1, p};
      @(posedge sys_clk_i);
      rei_i.valid <= 1'b0;
      #1;
      `CHK(rei_o, exp)
   endtask : rei_go

   task automatic addr_go(input logic [15:0] a, input logic v);
      @(posedge sys_clk_i);
      caddr_valid_i <= 1'b1;
      caddr_i <= a;
      @(posedge sys_clk_i);
      caddr_valid_i <= 1'b0;
      #1;
      `CHK(vaddr_valid_o, v)
      if (v)
         `CHK({vaddr_o, vpage_o}, {16'h0000, a, a[15:9]})
   endtask : addr_go

   task automatic exc_go(input lmc_pkg::lmc_exc_kind_t kd, input int nw, input logic [31:0] w0);
      int base, k;
      base = i_lmc_core_model.n;
      @(posedge sys_clk_i);
      exc_i <= '{1'b1, kd, 1'b1, 16'h1234, PC};
      @(posedge sys_clk_i);
      exc_i.valid <= 1'b0;
      #1;
      `CHK({backup_o, legacy_mode_flag_o}, 2'b10)
      k = 0;
      while (exc_ready_o !== 1'b1 && k < 40) begin
         @(posedge sys_clk_i);
         k++;
      end
      repeat (3) @(posedge sys_clk_i);
      `CHK(i_lmc_core_model.n - base, nw)
      if (nw > 0)
         `CHK(i_lmc_core_model.words[base], w0)
      if (nw > 1)
         `CHK(i_lmc_core_model.words[base + 1], PC)
      if (nw > 2)
         `CHK(i_lmc_core_model.words[base + 2], 32'h00001234)
   endtask : exc_go

   initial begin
      repeat (12) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      #1;
      `CHK({status_longword_o, exc_ready_o, irq_o}, {32'h03C00000, 2'b10})
      wb_rd(lmc_pkg::REG_IRQ_MASK, 32'h0);
      wb_wr(8'h24, 32'hFFFFFFFF, 4'hF);
      wb_rd(8'h24, 32'h0);
      wb_wr(lmc_pkg::REG_IRQ_MASK, 32'hF, 4'hF);
      foreach (bad[i])
         rei_go(bad[i], 3'b110);
      `CHK({legacy_mode_flag_o, irq_o}, 2'b01)
      rei_go(32'h03C0001A, 3'b100);
      rei_go(32'h83C0001A, 3'b101);
      `CHK({legacy_mode_flag_o, status_longword_o}, {1'b1, 32'h83C0001A})
      @(posedge sys_clk_i);
      lret_valid_i <= 1'b1;
      lret_psw_i <= 16'hFFE5;
      @(posedge sys_clk_i);
      lret_valid_i <= 1'b0;
      #1;
      `CHK(status_longword_o, 32'h83C00005)
      wb_rd(lmc_pkg::REG_STATUS, 32'h51);
      @(posedge sys_clk_i);
      cc_valid_i <= 1'b1;
      cc_i <= 4'h9;
      @(posedge sys_clk_i);
      cc_valid_i <= 1'b0;
      #1;
      `CHK(status_longword_o, 32'h83C00009)
      foreach (adrs[i])
         addr_go(adrs[i], 1'b1);
      slow_i <= 1'b1;
      exc_go(lmc_pkg::LMC_EXC_COMPAT, 3, 32'h83C00009);
      addr_go(16'h1000, 1'b0);
      slow_i <= 1'b0;
      rei_go(32'h83C00000, 3'b101);
      exc_go(lmc_pkg::LMC_EXC_TRACE, 2, 32'h83C00000);
      rei_go(32'h83C00000, 3'b101);
      exc_go(lmc_pkg::LMC_EXC_COMPAT, 3, 32'h83C00000);
      rei_go(32'h83C00000, 3'b101);
      exc_go(lmc_pkg::LMC_EXC_NATIVE, 0, 32'h0);
      // all four event kinds have fired by now
      wb_rd(lmc_pkg::REG_IRQ_STAT, 32'hF);
      wb_wr(lmc_pkg::REG_IRQ_MASK, 32'h0, 4'hE);
      `CHK(irq_o, 1'b1)
      wb_wr(lmc_pkg::REG_IRQ_MASK, 32'h0, 4'hF);
      `CHK(irq_o, 1'b0)
      wb_rd(lmc_pkg::REG_IRQ_STAT, 32'hF);
      wb_wr(lmc_pkg::REG_IRQ_STAT, 32'hF, 4'hF);
      wb_rd(lmc_pkg::REG_IRQ_STAT, 32'h0);
      wb_wr(lmc_pkg::REG_IRQ_MASK, 32'hF, 4'hF);
      `CHK(irq_o, 1'b0)
      finish_test();
   end

   // the whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      finish_test();
   end
endmodule : lmc_mode_ctrl_tb_top
`default_nettype wire
